// ### rtl/pesd_cfg.svh
// register offsets, field positions, event codes and reset values of the event counter
`ifndef PESD_CFG_SVH
`define PESD_CFG_SVH

`define PESD_ADDR_W          12
`define PESD_OFF_EVTSEL      12'h000
`define PESD_OFF_COUNT       12'h004
`define PESD_OFF_STATUS      12'h008

`define PESD_EVTSEL_CODE_LSB 0
`define PESD_EVTSEL_MASK_LSB 8
`define PESD_EVTSEL_EDGE_BIT 18
`define PESD_EVTSEL_EN_BIT   22
`define PESD_STATUS_OVF_BIT  0
`define PESD_STATUS_HIT_BIT  1

`define PESD_RST_CODE        8'h00
`define PESD_RST_MASK        8'h00
`define PESD_RST_COUNT       32'h0000_0000

`define PESD_EV_SEG_LOAD     8'h06
`define PESD_EV_UNHALTED     8'h79
`define PESD_EV_RES_STALL    8'hA2
`define PESD_EV_SIMD_EXEC    8'hB0
`define PESD_EV_SIMD_SAT     8'hB1
`define PESD_EV_SIMD_CLASS   8'hB3
`define PESD_EV_FP_SIMD      8'hCC
`define PESD_EV_SIMD_ASSIST  8'hCD
`define PESD_EV_SIMD_RET     8'hCE
`define PESD_EV_PART_ALIAS   8'hD2
`define PESD_EV_SEG_STALL    8'hD4
`define PESD_EV_SEG_RENAME   8'hD5
`define PESD_EV_SEG_RET      8'hD6
`define PESD_EV_BR_CLEAR     8'hE6

`define PESD_UM_NONE         8'h00
`define PESD_UM_TO_SIMD      8'h01
`define PESD_UM_CLS_MUL      8'h01
`define PESD_UM_CLS_SHIFT    8'h02
`define PESD_UM_CLS_PACK     8'h04
`define PESD_UM_CLS_UNPACK   8'h08
`define PESD_UM_CLS_LOGIC    8'h10
`define PESD_UM_CLS_ARITH    8'h20
`define PESD_UM_SEG_ES       8'h01
`define PESD_UM_SEG_DS       8'h02
`define PESD_UM_SEG_FS       8'h04
`define PESD_UM_SEG_GS       8'h08
`define PESD_UM_SEG_ALL      8'h0F

`endif

// ### rtl/pesd_pkg.sv
// types of the event-select and counting block
package pesd_pkg;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  umask;
    logic        edge_mode;
    logic        enable;
    logic [31:0] count;
    logic        ovf;
    logic        prev_hit;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } pesd_state_type;

endpackage : pesd_pkg

// ### rtl/pesd_seg_match.sv
// segment mask qualifier: counts selected segment events for one event code
`timescale 1ns/1ns
`include "pesd_cfg.svh"
module pesd_seg_match
  import pesd_pkg::*;
(
  input  wire logic [7:0] umask,
  input  wire logic [3:0] seg_events,
  output      logic [2:0] amount
);

  function automatic logic [2:0] pesd_pop4(input logic [3:0] v);
    pesd_pop4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
  endfunction : pesd_pop4

  always_comb begin
    case (umask)
      `PESD_UM_SEG_ES,
      `PESD_UM_SEG_DS,
      `PESD_UM_SEG_FS,
      `PESD_UM_SEG_GS,
      `PESD_UM_SEG_ALL: amount = pesd_pop4(umask[3:0] & seg_events);
      default:          amount = 3'h0;
    endcase
  end

endmodule : pesd_seg_match

// ### rtl/pesd_top.sv
// event selection, counting and apb register file of one performance counter
//
// Contract
// - Code E6H with mask 00H counts each assertion of the branch-address-clear signal.
// - Code A2H adds one each cycle with a resource stall (rename or memory buffers full).
// - The resource-stall event ignores full-bus-queue and excess-cache-miss stalls.
// - The resource-stall event also counts mispredict-recovery and store-drain stalls.
// - Code D2H counts partial register-alias stalls, flag partial stalls included.
// - Code 06H with mask 00H counts one per segment register load.
// - Code 79H counts every cycle in which the core is not halted.
// - The packed-integer executed event skips quad and dword move stores.
// - Code B1H counts each executed saturating packed-integer instruction.
// - The class event mask picks multiply, shift, pack, unpack, logical or arithmetic.
// - Code CCH counts simd-to-float transitions with mask 00H and the reverse with mask 01H.
// - Code CDH counts executed instructions that empty the packed-integer state.
// - Code CEH counts each retired packed-integer instruction.
// - Codes D4H and D5H count segment rename stalls and renames for one masked segment, or for all four with mask 0FH; other masks count nothing.
// - Code D6H counts each retired segment-register rename.
`timescale 1ns/1ns
`include "pesd_cfg.svh"
module pesd_top
  import pesd_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [`PESD_ADDR_W-1:0] paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output      logic [31:0]             prdata,
  output      logic                    pready,
  output      logic                    pslverr,
  input  wire logic                    branch_addr_clear,
  input  wire logic                    stall_rename_buf,
  input  wire logic                    stall_mem_buf,
  input  wire logic                    stall_mispredict_recovery,
  input  wire logic                    stall_store_drain,
  input  wire logic                    stall_bus_queue_full,
  input  wire logic                    stall_miss_limit,
  input  wire logic                    partial_alias_stalls,
  input  wire logic                    partial_flag_stall,
  input  wire logic                    seg_load,
  input  wire logic                    core_halted,
  input  wire logic                    simd_int_executed,
  input  wire logic                    simd_store_move,
  input  wire logic                    simd_saturating_executed,
  input  wire logic [5:0]              simd_class_executed,
  input  wire logic                    simd_to_float,
  input  wire logic                    float_to_simd,
  input  wire logic                    empty_simd_state_instr,
  input  wire logic                    simd_int_retired,
  input  wire logic [3:0]              seg_rename_stall_count,
  input  wire logic [3:0]              seg_rename_count,
  input  wire logic                    retired_seg_rename_count,
  output      logic [31:0]             count_value,
  output      logic                    count_overflow
);

  pesd_state_type state_q;
  pesd_state_type state_d;

  logic [2:0]  seg_stall_amount;
  logic [2:0]  seg_rename_amount;
  logic [2:0]  incr;
  logic        hit;
  logic        res_stall;
  logic        alias_stall;
  logic        simd_exec_cnt;
  logic        setup;
  logic        access;
  logic        wr_evtsel;
  logic        wr_count;
  logic        wr_status;
  logic [31:0] evtsel_word;
  logic [31:0] status_word;
  logic [31:0] count_new;
  logic [32:0] sum;
  logic [2:0]  step;

  // byte-lane merge for apb writes
  function automatic logic [31:0] pesd_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    pesd_merge = res;
  endfunction : pesd_merge

  // a single-bit condition counted only when the mask is the plain 00H
  function automatic logic [2:0] pesd_plain(input logic [7:0] um, input logic cond);
    pesd_plain = (um == `PESD_UM_NONE) ? {2'b00, cond} : 3'h0;
  endfunction : pesd_plain

  pesd_seg_match u_seg_stall (
    .umask      (state_q.umask),
    .seg_events (seg_rename_stall_count),
    .amount     (seg_stall_amount)
  );

  pesd_seg_match u_seg_rename (
    .umask      (state_q.umask),
    .seg_events (seg_rename_count),
    .amount     (seg_rename_amount)
  );

  // resource stall: bus-queue and miss-limit stalls carry no weight here
  assign res_stall     = stall_rename_buf | stall_mem_buf
                       | stall_mispredict_recovery | stall_store_drain;
  // stall_bus_queue_full and stall_miss_limit are deliberately not in res_stall
  assign alias_stall   = partial_alias_stalls | partial_flag_stall;
  assign simd_exec_cnt = simd_int_executed & ~simd_store_move;

  always_comb begin
    case (state_q.code)
      `PESD_EV_BR_CLEAR:    incr = pesd_plain(state_q.umask, branch_addr_clear);
      `PESD_EV_RES_STALL:   incr = pesd_plain(state_q.umask, res_stall);
      `PESD_EV_PART_ALIAS:  incr = pesd_plain(state_q.umask, alias_stall);
      `PESD_EV_SEG_LOAD:    incr = pesd_plain(state_q.umask, seg_load);
      `PESD_EV_UNHALTED:    incr = pesd_plain(state_q.umask, ~core_halted);
      `PESD_EV_SIMD_EXEC:   incr = pesd_plain(state_q.umask, simd_exec_cnt);
      `PESD_EV_SIMD_SAT: incr = pesd_plain(state_q.umask, simd_saturating_executed);
      `PESD_EV_SIMD_CLASS: begin
        case (state_q.umask)
          `PESD_UM_CLS_MUL:    incr = {2'b00, simd_class_executed[0]};
          `PESD_UM_CLS_SHIFT:  incr = {2'b00, simd_class_executed[1]};
          `PESD_UM_CLS_PACK:   incr = {2'b00, simd_class_executed[2]};
          `PESD_UM_CLS_UNPACK: incr = {2'b00, simd_class_executed[3]};
          `PESD_UM_CLS_LOGIC:  incr = {2'b00, simd_class_executed[4]};
          `PESD_UM_CLS_ARITH:  incr = {2'b00, simd_class_executed[5]};
          default:             incr = 3'h0;
        endcase
      end
      `PESD_EV_FP_SIMD: begin
        case (state_q.umask)
          `PESD_UM_NONE:    incr = {2'b00, simd_to_float};
          `PESD_UM_TO_SIMD: incr = {2'b00, float_to_simd};
          default:          incr = 3'h0;
        endcase
      end
      `PESD_EV_SIMD_ASSIST: incr = pesd_plain(state_q.umask, empty_simd_state_instr);
      `PESD_EV_SIMD_RET:    incr = pesd_plain(state_q.umask, simd_int_retired);
      `PESD_EV_SEG_STALL:   incr = seg_stall_amount;
      `PESD_EV_SEG_RENAME:  incr = seg_rename_amount;
      `PESD_EV_SEG_RET: incr = pesd_plain(state_q.umask, retired_seg_rename_count);
      default:              incr = 3'h0;
    endcase
  end

  assign hit = (incr != 3'h0);

  // edge mode counts one per rising edge of the selected condition
  always_comb begin
    if (!state_q.enable) begin
      step = 3'h0;
    end else if (state_q.edge_mode) begin
      step = (hit && !state_q.prev_hit) ? 3'h1 : 3'h0;
    end else begin
      step = incr;
    end
  end

  assign sum = {1'b0, state_q.count} + {30'h0000_0000, step};

  // apb decode: answer is prepared in setup, given in the first access cycle
  assign setup     = psel & ~penable;
  assign access    = psel & penable & state_q.ready;
  assign wr_evtsel = access & pwrite & (paddr == `PESD_OFF_EVTSEL);
  assign wr_count  = access & pwrite & (paddr == `PESD_OFF_COUNT);
  assign wr_status = access & pwrite & (paddr == `PESD_OFF_STATUS);

  always_comb begin
    evtsel_word = 32'h0000_0000;
    evtsel_word[`PESD_EVTSEL_CODE_LSB +: 8] = state_q.code;
    evtsel_word[`PESD_EVTSEL_MASK_LSB +: 8] = state_q.umask;
    evtsel_word[`PESD_EVTSEL_EDGE_BIT]      = state_q.edge_mode;
    evtsel_word[`PESD_EVTSEL_EN_BIT]        = state_q.enable;
    status_word = 32'h0000_0000;
    status_word[`PESD_STATUS_OVF_BIT] = state_q.ovf;
    status_word[`PESD_STATUS_HIT_BIT] = state_q.prev_hit;
  end

  assign count_new = pesd_merge(state_q.count, pwdata, pstrb);

  always_comb begin
    logic [31:0] sel_new;
    sel_new = pesd_merge(evtsel_word, pwdata, pstrb);
    state_d = state_q;
    state_d.prev_hit = hit;
    // software load of the counter takes precedence over a same-cycle increment
    if (wr_count) begin
      state_d.count = count_new;
    end else begin
      state_d.count = sum[31:0];
    end
    // overflow is sticky; a wrap in the clearing cycle keeps it set
    if (wr_status && pstrb[0] && pwdata[`PESD_STATUS_OVF_BIT]) begin
      state_d.ovf = 1'b0;
    end
    if (!wr_count && sum[32]) begin
      state_d.ovf = 1'b1;
    end
    if (wr_evtsel) begin
      state_d.code      = sel_new[`PESD_EVTSEL_CODE_LSB +: 8];
      state_d.umask     = sel_new[`PESD_EVTSEL_MASK_LSB +: 8];
      state_d.edge_mode = sel_new[`PESD_EVTSEL_EDGE_BIT];
      state_d.enable    = sel_new[`PESD_EVTSEL_EN_BIT];
    end
    state_d.ready  = setup;
    state_d.slverr = 1'b0;
    state_d.rdata  = 32'h0000_0000;
    if (setup) begin
      case (paddr)
        `PESD_OFF_EVTSEL: state_d.rdata  = pwrite ? 32'h0000_0000 : evtsel_word;
        `PESD_OFF_COUNT:  state_d.rdata  = pwrite ? 32'h0000_0000 : state_q.count;
        `PESD_OFF_STATUS: state_d.rdata  = pwrite ? 32'h0000_0000 : status_word;
        default:          state_d.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q.code      <= `PESD_RST_CODE;
      state_q.umask     <= `PESD_RST_MASK;
      state_q.edge_mode <= 1'b0;
      state_q.enable    <= 1'b0;
      state_q.count     <= `PESD_RST_COUNT;
      state_q.ovf       <= 1'b0;
      state_q.prev_hit  <= 1'b0;
      state_q.rdata     <= 32'h0000_0000;
      state_q.ready     <= 1'b0;
      state_q.slverr    <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata         = state_q.rdata;
  assign pready         = state_q.ready;
  assign pslverr        = state_q.slverr;
  assign count_value    = state_q.count;
  assign count_overflow = state_q.ovf;

endmodule : pesd_top

// ### verification/pesd_core_model.sv
// behavioural core pipeline that raises event strobes on request
`timescale 1ns/1ns
module pesd_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        fire,
  input  wire logic [32:0] pattern,
  output      logic [32:0] core_events
);
  // core sits halted between bursts so the unhalted-cycle event stays quiet
  localparam logic [32:0] IDLE_EVENTS = 33'h0_0000_0400;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) core_events <= IDLE_EVENTS;
    else core_events <= fire ? pattern : IDLE_EVENTS;
  end
endmodule : pesd_core_model

// ### verification/pesd_top_checker.sv
// concurrent checks on the event counter ports
`timescale 1ns/1ns
`include "pesd_cfg.svh"
module pesd_top_checker
  import pesd_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic [`PESD_ADDR_W-1:0] paddr,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    branch_addr_clear,
  input wire logic                    stall_rename_buf,
  input wire logic                    stall_mem_buf,
  input wire logic                    stall_mispredict_recovery,
  input wire logic                    stall_store_drain,
  input wire logic                    partial_alias_stalls,
  input wire logic                    partial_flag_stall,
  input wire logic                    core_halted,
  input wire logic                    simd_store_move,
  input wire logic                    simd_saturating_executed,
  input wire logic [3:0]              seg_rename_count,
  input wire logic [31:0]             count_value
);
  logic [22:0] cfg_q;
  logic        wr;
  logic        on;
  logic        res;
  logic [7:0]  code_w;
  logic [7:0]  mask_w;
  assign wr = psel && penable && pready && pwrite;
  assign on = cfg_q[22] && !cfg_q[18] && !wr;
  assign code_w = cfg_q[7:0];
  assign mask_w = cfg_q[15:8];
  assign res = stall_rename_buf || stall_mem_buf || stall_mispredict_recovery || stall_store_drain;
  // shadow of the event-select word, built from observed apb writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg_q <= 23'h0;
    else if (wr && paddr == `PESD_OFF_EVTSEL) cfg_q <= pwdata[22:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_bac_inc: assert property (
    on && code_w == 8'hE6 && mask_w == 8'h00 && branch_addr_clear
    |=> count_value == $past(count_value) + 32'h1) else $error("branch clear missed");
  chk_stall_inc: assert property (
    on && code_w == 8'hA2 && mask_w == 8'h00 && res
    |=> count_value == $past(count_value) + 32'h1) else $error("stall missed");
  chk_stall_excl: assert property (
    on && code_w == 8'hA2 && !res |=> $stable(count_value)) else $error("stall miscounted");
  chk_partial_inc: assert property (
    on && code_w == 8'hD2 && mask_w == 8'h00 && (partial_alias_stalls || partial_flag_stall)
    |=> count_value == $past(count_value) + 32'h1) else $error("partial stall missed");
  chk_unhalted_inc: assert property (
    on && code_w == 8'h79 && mask_w == 8'h00 && !core_halted
    |=> count_value == $past(count_value) + 32'h1) else $error("unhalted missed");
  chk_move_excl: assert property (
    on && code_w == 8'hB0 && simd_store_move |=> $stable(count_value)) else $error("move counted");
  chk_sat_inc: assert property (
    on && code_w == 8'hB1 && mask_w == 8'h00 && simd_saturating_executed
    |=> count_value == $past(count_value) + 32'h1) else $error("saturating missed");
  chk_seg_all: assert property (
    on && code_w == 8'hD5 && mask_w == 8'h0F
    |=> count_value - $past(count_value) == $countones($past(seg_rename_count)))
    else $error("rename sum wrong");
  chk_off_hold: assert property (
    !cfg_q[22] && !wr |=> $stable(count_value)) else $error("count moved while off");
  chk_ready_pulse: assert property (
    psel && !penable |=> pready ##1 !pready) else $error("ready not one pulse");
  cover property (on && code_w == 8'hE6 && branch_addr_clear);
  cover property (on && code_w == 8'hD5 && seg_rename_count != 4'h0);
  cover property (on && code_w == 8'hA2 && res);
endmodule : pesd_top_checker

bind pesd_top pesd_top_checker u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pready, .branch_addr_clear, .stall_rename_buf, .stall_mem_buf,
  .stall_mispredict_recovery, .stall_store_drain, .partial_alias_stalls, .partial_flag_stall,
  .core_halted, .simd_store_move, .simd_saturating_executed, .seg_rename_count, .count_value);

// ### verification/test_perf_event_select_decoder.sv
// self-checking bench for the event counter
`timescale 1ns/1ns
`include "pesd_cfg.svh"
module test_perf_event_select_decoder;
  import pesd_pkg::*;
  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  mask;
    logic [32:0] pat;
    logic [2:0]  exp;
  } pesd_row_type;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        fire = 1'b0;
  logic [32:0] pattern = 33'h0;
  wire  [32:0] ev;
  wire  [31:0] prdata;
  wire  [31:0] count_value;
  wire         pready;
  wire         pslverr;
  wire         count_overflow;
  int          num_errors = 0;
  int          n_tests = 0;
  int          k;
  pesd_row_type rows [25] = '{
    '{8'hE6,8'h00,33'h1,3'h1}, '{8'hE6,8'h01,33'h1,3'h0}, '{8'hA2,8'h00,33'h6,3'h1},
    '{8'hA2,8'h00,33'h60,3'h0}, '{8'hA2,8'h00,33'h8,3'h1}, '{8'hA2,8'h00,33'h10,3'h1},
    '{8'hD2,8'h00,33'h80,3'h1}, '{8'hD2,8'h00,33'h100,3'h1}, '{8'h06,8'h00,33'h200,3'h1},
    '{8'h79,8'h00,33'h0,3'h1}, '{8'hB0,8'h00,33'h800,3'h1}, '{8'hB0,8'h00,33'h1800,3'h0},
    '{8'hB1,8'h00,33'h2000,3'h1}, '{8'hCC,8'h00,33'h10_0000,3'h1},
    '{8'hCC,8'h01,33'h20_0000,3'h1}, '{8'hCC,8'h00,33'h20_0000,3'h0},
    '{8'hCD,8'h00,33'h40_0000,3'h1}, '{8'hCE,8'h00,33'h80_0000,3'h1},
    '{8'hD4,8'h0F,33'hF00_0000,3'h4}, '{8'hD4,8'h02,33'hF00_0000,3'h1},
    '{8'hD5,8'h0F,33'h5000_0000,3'h2}, '{8'hD5,8'h03,33'h5000_0000,3'h0},
    '{8'hD6,8'h00,33'h1_0000_0000,3'h1}, '{8'h00,8'h00,33'h1_FFFF_FBFF,3'h0},
    '{8'hB3,8'h03,33'hF_C000,3'h0}};
  always #10 pclk = ~pclk;
  pesd_core_model u_core (.pclk(pclk), .presetn(presetn), .fire(fire), .pattern(pattern),
    .core_events(ev));
  pesd_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .branch_addr_clear(ev[0]), .stall_rename_buf(ev[1]),
    .stall_mem_buf(ev[2]), .stall_mispredict_recovery(ev[3]), .stall_store_drain(ev[4]),
    .stall_bus_queue_full(ev[5]), .stall_miss_limit(ev[6]), .partial_alias_stalls(ev[7]),
    .partial_flag_stall(ev[8]), .seg_load(ev[9]), .core_halted(ev[10]),
    .simd_int_executed(ev[11]), .simd_store_move(ev[12]), .simd_saturating_executed(ev[13]),
    .simd_class_executed(ev[19:14]), .simd_to_float(ev[20]), .float_to_simd(ev[21]),
    .empty_simd_state_instr(ev[22]), .simd_int_retired(ev[23]),
    .seg_rename_stall_count(ev[27:24]), .seg_rename_count(ev[31:28]),
    .retired_seg_rename_count(ev[32]), .count_value(count_value),
    .count_overflow(count_overflow));
  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check32
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until the rising edge at which pready is seen high
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      num_errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check32(r, exp, "read data");
    check32({31'h0, e}, {31'h0, experr}, "slave error");
  endtask : rd_chk
  task automatic pulse(input logic [32:0] p, input int n);
    @(posedge pclk);
    pattern <= p; fire <= 1'b1;
    repeat (n) @(posedge pclk);
    fire <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic run(input logic [7:0] c, input logic [7:0] m, input logic en,
                     input logic [32:0] p, input int n);
    wr(`PESD_OFF_EVTSEL, {9'h0, en, 6'h0, m, c});
    wr(`PESD_OFF_COUNT, 32'h0);
    pulse(p, n);
  endtask : run
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check32(count_value, `PESD_RST_COUNT, "count reset");
    check32({31'h0, count_overflow}, 32'h0, "overflow reset");
    rd_chk(`PESD_OFF_EVTSEL, 32'h0, 1'b0);
    for (k = 0; k < 25; k++) begin
      run(rows[k].code, rows[k].mask, 1'b1, rows[k].pat, 1);
      check32(count_value, {29'h0, rows[k].exp}, "event row");
    end
    for (k = 0; k < 6; k++) begin
      run(8'hB3, 8'h01 << k, 1'b1, {13'h0, 6'h01 << k, 14'h0}, 1);
      check32(count_value, 32'h1, "class hit");
      run(8'hB3, 8'h01 << k, 1'b1, {13'h0, ~(6'h01 << k), 14'h0}, 1);
      check32(count_value, 32'h0, "class miss");
    end
    run(8'hE6, 8'h00, 1'b0, 33'h1, 1);
    check32(count_value, 32'h0, "disabled");
    run(8'hA2, 8'h00, 1'b1, 33'h2, 3);
    check32(count_value, 32'h3, "back to back");
    wr(`PESD_OFF_COUNT, 32'hFFFF_FFFF);
    pulse(33'h6, 1);
    check32(count_value, 32'h0, "wrap");
    check32({31'h0, count_overflow}, 32'h1, "overflow set");
    rd_chk(`PESD_OFF_STATUS, 32'h1, 1'b0);
    wr(`PESD_OFF_STATUS, 32'h1);
    @(posedge pclk);
    check32({31'h0, count_overflow}, 32'h0, "overflow clear");
    // edge mode: a three-cycle stall counts once
    wr(`PESD_OFF_EVTSEL, 32'h0044_00A2);
    wr(`PESD_OFF_COUNT, 32'h0);
    pulse(33'h2, 3);
    check32(count_value, 32'h1, "edge mode");
    rd_chk(12'h00C, 32'h0, 1'b1);
    wr(`PESD_OFF_EVTSEL, 32'hFFFF_FFFF);
    rd_chk(`PESD_OFF_EVTSEL, 32'h0044_FFFF, 1'b0);
    // reset in mid-run clears a loaded counter and the selection
    wr(`PESD_OFF_COUNT, 32'h0000_0005);
    @(posedge pclk);
    check32(count_value, 32'h0000_0005, "count load");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check32(count_value, `PESD_RST_COUNT, "count after reset");
    check32({31'h0, count_overflow}, 32'h0, "overflow after reset");
    rd_chk(`PESD_OFF_EVTSEL, 32'h0, 1'b0);
    report_and_stop();
  end
endmodule : test_perf_event_select_decoder
